// ---- include/dac_loader_pkg.sv ----
// Package with constants and carriers for the dual converter serial loader
// Overview of operation
// - Buffer-only write stores code in double buffer; latches A and B unchanged.
// - Latch A write loads latch A and copies double buffer into latch B together.
// - Double buffer equals latch B except after buffer-only write.
// - Latch B write puts twelve low bits into latch B and buffer; A untouched.
// - Bit fourteen selects speed: zero slow, one fast, for every write.
// - Buffer-only load: top bit zero, power-down zero, bit twelve one, code.
// - Latch A load: top bit one, power-down zero, then twelve-bit code.
// - Latch B load: top bit zero, bit twelve zero, power-down zero, code.
// - After reset latches A and B hold zero until first write.
// - While select low, shift one bit per falling serial clock, MSB first.
// - Select rising edge triggers the latch transfer chosen by command bits.
package dac_loader_pkg;
  localparam int WORD_W           = 16;
  localparam int LATCH_W          = 12;
  localparam int LATCH_A_SEL_POS  = 15;
  localparam int SPEED_POS        = 14;
  localparam int POWER_DOWN_POS   = 13;
  localparam int BUFFER_ONLY_POS  = 12;
  localparam logic [11:0] LATCH_RESET = 12'h000;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;

  typedef struct packed {
    logic [2:0]  sclk_sync;
    logic [2:0]  csn_sync;
    logic [15:0] input_shift_register;
    logic [11:0] latch_a;
    logic [11:0] latch_b;
    logic [11:0] double_buffer;
    logic        fast_mode;
    logic        power_down;
    logic        update;
  } loader_state_t;
endpackage

// ---- rtl/dual_dac_double_buffer_loader.sv ----
// Serial command receiver and double-buffered latch set for a dual converter
`timescale 1ns/1ps
module dual_dac_double_buffer_loader
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        serial_clk,
  input  wire logic        serial_data,
  input  wire logic        chip_select_n,
  output logic [11:0]      code_a,
  output logic [11:0]      code_b,
  output logic             fast_mode,
  output logic             power_down,
  output logic             update_pulse
);
  // All state lives in one struct; the comb block edits a copy.
  // Keeping every field in one place makes reset coverage easy to audit,
  // at the cost of a slightly wider always_ff.
  dac_loader_pkg::loader_state_t st_r;
  dac_loader_pkg::loader_state_t st_nxt;

  logic sclk_fall;
  logic cs_rise;
  logic cs_low;

  // Edges detected when stage two shows the new level and stage three still the old one
  assign sclk_fall = !st_r.sclk_sync[1] && st_r.sclk_sync[2];
  assign cs_rise   = st_r.csn_sync[1] && !st_r.csn_sync[2];
  assign cs_low    = !st_r.csn_sync[2];

  // Next state; data pin is sampled late enough since the clock edge lags by two stages
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.update    = 1'b0;
    st_nxt.sclk_sync = {st_r.sclk_sync[1:0], serial_clk};
    st_nxt.csn_sync  = {st_r.csn_sync[1:0], chip_select_n};
    if (sclk_fall && cs_low)
    begin
      st_nxt.input_shift_register =
        {st_r.input_shift_register[14:0], serial_data};
    end
    // Odd edge counts are not flagged; whatever sits in the register is used
    if (cs_rise)
    begin
      st_nxt.update     = 1'b1;
      st_nxt.fast_mode  = st_r.input_shift_register[dac_loader_pkg::SPEED_POS];
      st_nxt.power_down = st_r.input_shift_register[dac_loader_pkg::POWER_DOWN_POS];
      if (st_r.input_shift_register[dac_loader_pkg::LATCH_A_SEL_POS])
      begin
        st_nxt.latch_a = st_r.input_shift_register[11:0];
        st_nxt.latch_b = st_r.double_buffer;
      end
      else if (st_r.input_shift_register[dac_loader_pkg::BUFFER_ONLY_POS])
      begin
        st_nxt.double_buffer = st_r.input_shift_register[11:0];
      end
      else
      begin
        st_nxt.latch_b       = st_r.input_shift_register[11:0];
        st_nxt.double_buffer = st_r.input_shift_register[11:0];
      end
    end
  end

  // Reset idles synchronisers at select high so no false edge follows release
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_r.sclk_sync            <= 3'h0;
      st_r.csn_sync             <= 3'h7;
      st_r.input_shift_register <= dac_loader_pkg::SHIFT_RESET;
      st_r.latch_a              <= dac_loader_pkg::LATCH_RESET;
      st_r.latch_b              <= dac_loader_pkg::LATCH_RESET;
      st_r.double_buffer        <= dac_loader_pkg::LATCH_RESET;
      st_r.fast_mode            <= 1'b0;
      st_r.power_down           <= 1'b0;
      st_r.update               <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from flip-flops, so they never glitch
  assign code_a       = st_r.latch_a;
  assign code_b       = st_r.latch_b;
  assign fast_mode    = st_r.fast_mode;
  assign power_down   = st_r.power_down;
  assign update_pulse = st_r.update;

  property p_buffer_only;
    @(posedge clk_sys) disable iff (reset)
    (cs_rise && !st_r.input_shift_register[15] && st_r.input_shift_register[12])
    |=> ($stable(code_a) && $stable(code_b)
         && st_r.double_buffer == $past(st_r.input_shift_register[11:0]));
  endproperty
  a_buffer_only: assert property (p_buffer_only) else $error("buffer-only write wrong");

  property p_latch_a;
    @(posedge clk_sys) disable iff (reset)
    (cs_rise && st_r.input_shift_register[15])
    |=> (code_a == $past(st_r.input_shift_register[11:0])
         && code_b == $past(st_r.double_buffer));
  endproperty
  a_latch_a: assert property (p_latch_a) else $error("latch A write wrong");

  property p_latch_b;
    @(posedge clk_sys) disable iff (reset)
    (cs_rise && !st_r.input_shift_register[15] && !st_r.input_shift_register[12])
    |=> ($stable(code_a) && code_b == $past(st_r.input_shift_register[11:0])
         && st_r.double_buffer == code_b);
  endproperty
  a_latch_b: assert property (p_latch_b) else $error("latch B write wrong");

  property p_speed;
    @(posedge clk_sys) disable iff (reset)
    cs_rise |=> fast_mode == $past(st_r.input_shift_register[14]);
  endproperty
  a_speed: assert property (p_speed) else $error("speed bit not applied");

  property p_power;
    @(posedge clk_sys) disable iff (reset)
    cs_rise |=> power_down == $past(st_r.input_shift_register[13]);
  endproperty
  a_power: assert property (p_power) else $error("power bit not applied");

  property p_hold;
    @(posedge clk_sys) disable iff (reset)
    !cs_rise |=> ($stable(code_a) && $stable(code_b) && !update_pulse);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without select rise");

  property p_shift;
    @(posedge clk_sys) disable iff (reset)
    (sclk_fall && cs_low)
    |=> st_r.input_shift_register[15:1] == $past(st_r.input_shift_register[14:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift register did not shift");

  property p_reset_zero;
    @(posedge clk_sys) $past(reset) |-> (code_a == 12'h000 && code_b == 12'h000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("latches not zero after reset");

  property p_update;
    @(posedge clk_sys) disable iff (reset)
    cs_rise |=> update_pulse ##1 !update_pulse;
  endproperty
  a_update: assert property (p_update) else $error("update pulse wrong");

  // Double buffer only moves on a select rise
  property p_buffer_stable;
    @(posedge clk_sys) disable iff (reset)
    !cs_rise |=> $stable(st_r.double_buffer);
  endproperty
  a_buffer_stable: assert property (p_buffer_stable) else $error("buffer moved");

  // A latch A write copies the buffer out but leaves it as it was
  property p_latch_a_keeps_buffer;
    @(posedge clk_sys) disable iff (reset)
    (cs_rise && st_r.input_shift_register[15]) |=> $stable(st_r.double_buffer);
  endproperty
  a_latch_a_keeps_buffer: assert property (p_latch_a_keeps_buffer) else $error("buffer hit");

  // The update pulse is always caused by a detected select rise
  property p_update_cause;
    @(posedge clk_sys) disable iff (reset)
    update_pulse |-> $past(cs_rise);
  endproperty
  a_update_cause: assert property (p_update_cause) else $error("update without select");

  // Without a qualified falling edge the shift register holds
  property p_shift_idle;
    @(posedge clk_sys) disable iff (reset)
    !(sclk_fall && cs_low) |=> $stable(st_r.input_shift_register);
  endproperty
  a_shift_idle: assert property (p_shift_idle) else $error("shift register moved");

  // The newest bit enters at the bottom, so the first bit ends on top
  property p_shift_lsb;
    @(posedge clk_sys) disable iff (reset)
    (sclk_fall && cs_low) |=> st_r.input_shift_register[0] == $past(serial_data);
  endproperty
  a_shift_lsb: assert property (p_shift_lsb) else $error("wrong bit shifted in");

  // The update strobe never lasts two cycles
  property p_pulse_single;
    @(posedge clk_sys) disable iff (reset)
    update_pulse |=> !update_pulse;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("update pulse too long");

  // Mode bits are levels that only a write may change
  property p_mode_stable;
    @(posedge clk_sys) disable iff (reset)
    !cs_rise |=> ($stable(fast_mode) && $stable(power_down));
  endproperty
  a_mode_stable: assert property (p_mode_stable) else $error("mode changed without write");

  // Reset leaves the modes cleared and no pending update
  property p_reset_modes;
    @(posedge clk_sys) $past(reset) |-> (!update_pulse && !fast_mode && !power_down);
  endproperty
  a_reset_modes: assert property (p_reset_modes) else $error("modes not clear after reset");
endmodule

// ---- testbench/serial_host.sv ----
// Serial host model that shifts command words into the loader
`timescale 1ns/1ps
module serial_host
(
  input  wire logic clk_sys,
  output logic      serial_clk,
  output logic      serial_data,
  output logic      chip_select_n
);
  initial
  begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    chip_select_n = 1'b1;
  end
  // One frame of n bits, 200 ns bit period; a 16-bit word goes in one frame
  task automatic send(input logic [15:0] w, input int n);
    chip_select_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 15; i > 15 - n; i--)
    begin
      serial_clk <= 1'b1;
      serial_data <= w[i];
      repeat (4) @(posedge clk_sys);
      serial_clk <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    chip_select_n <= 1'b1;
    serial_data <= ~serial_data; // Released line must not show the last bit
    @(posedge clk_sys);
  endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the dual converter serial loader
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [15:0] word;
    logic [11:0] ea;
    logic [11:0] eb;
    logic [1:0]  fp;   // Fast mode then power down
  } row_t;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        serial_clk;
  logic        serial_data;
  logic        chip_select_n;
  logic [11:0] code_a;
  logic [11:0] code_b;
  logic        fast_mode;
  logic        power_down;
  logic        update_pulse;
  int          err_count = 0;
  int          samples_checked = 0;
  // Buffer-only row keeps the prior speed bit so outputs do not glitch
  row_t rows [6] = '{{16'h4ffc, 12'h000, 12'hffc, 2'b10}, {16'h8800, 12'h800, 12'hffc, 2'b00},
    {16'h1557, 12'h800, 12'hffc, 2'b00}, {16'h8004, 12'h004, 12'h557, 2'b00},
    {16'h2003, 12'h004, 12'h003, 2'b01}, {16'hc3f0, 12'h3f0, 12'h003, 2'b10}};
  always #12.5 clk_sys = ~clk_sys;
  serial_host host (.clk_sys(clk_sys), .serial_clk(serial_clk), .serial_data(serial_data),
    .chip_select_n(chip_select_n));
  dual_dac_double_buffer_loader uut (.clk_sys(clk_sys), .reset(reset),
    .serial_clk(serial_clk), .serial_data(serial_data), .chip_select_n(chip_select_n),
    .code_a(code_a), .code_b(code_b), .fast_mode(fast_mode), .power_down(power_down),
    .update_pulse(update_pulse));
  task automatic give_verdict;
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp12(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp12({11'h000, got}, {11'h000, exp});
  endtask
  // Send a frame, wait a bounded time for the update, then check all results
  task automatic frame(input row_t r, input int n);
    int k;
    k = 0;
    @(posedge clk_sys);
    host.send(r.word, n);
    while (update_pulse !== 1'b1 && k < 40)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k == 40)
    begin
      err_count++;
      give_verdict();
    end
    cmp12(code_a, r.ea);
    cmp12(code_b, r.eb);
    cmp1(fast_mode, r.fp[1]);
    cmp1(power_down, r.fp[0]);
    @(posedge clk_sys);
    #1;
    cmp1(update_pulse, 1'b0);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1;
    cmp12(code_a, 12'h000);
    cmp12(code_b, 12'h000);
    @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rows[i])
      frame(rows[i], 16);
    // Short frame: the last 16 shifted bits are taken, no error
    frame({16'h1200, 12'h012, 12'h003, 2'b11}, 8);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    cmp12(code_a, 12'h000);
    cmp12(code_b, 12'h000);
    @(posedge clk_sys);
    reset <= 1'b0;
    frame({16'h8800, 12'h800, 12'h000, 2'b00}, 16);
    give_verdict();
  end
endmodule
